/* srm_pkg.sv */
// Purpose: shared constants and types for the spi readback select mux
// Assumes: four switched outputs, 16-bit serial words, 9-bit readback payload
// Notes: command field layout and register reset codes are collected here
package srm_pkg;

  // sizes
  localparam int NUM_OUT = 4;
  localparam int DATA_W = 9;
  localparam int WORD_W = 16;
  localparam int SEL_W = 5;
  localparam int CNT_W = 8;
  localparam int POS_W = 5;

  // returned word layout
  localparam int WD_BIT = 15;
  localparam int SEL_HI = 14;
  localparam int SEL_LO = 10;
  localparam int NM_BIT = 9;
  localparam int FUNC_HI = 2;

  // received command layout
  localparam int CMD_OUT_HI = 14;
  localparam int CMD_OUT_LO = 13;
  localparam int CMD_ADDR_HI = 12;
  localparam int CMD_ADDR_LO = 9;
  localparam int PWM_ON_BIT = 7;

  // readback select codes, low three bits per output
  localparam logic [2:0] FUNC_STAT = 3'h0;
  localparam logic [2:0] FUNC_PWM = 3'h1;
  localparam logic [2:0] FUNC_CONF0 = 3'h2;
  localparam logic [2:0] FUNC_CONF1 = 3'h3;
  localparam logic [2:0] FUNC_OCR = 3'h4;

  // readback select codes, full address
  localparam logic [4:0] SEL_RST = 5'h00;
  localparam logic [4:0] SEL_GCR = 5'h05;
  localparam logic [4:0] SEL_DIAG0 = 5'h07;
  localparam logic [4:0] SEL_DIAG1 = 5'h0f;
  localparam logic [4:0] SEL_ID = 5'h17;

  // write command register addresses
  localparam logic [3:0] CMD_SEL = 4'h0;
  localparam logic [3:0] CMD_PWM = 4'h1;
  localparam logic [3:0] CMD_CONF0 = 4'h2;
  localparam logic [3:0] CMD_CONF1 = 4'h3;
  localparam logic [3:0] CMD_OCR = 4'h4;
  localparam logic [3:0] CMD_GCR = 4'h5;

  // power-up configuration codes
  localparam logic [8:0] PWM_RST = 9'h000;
  localparam logic [8:0] CONF0_RST = 9'h008;
  localparam logic [8:0] CONF1_RST = 9'h000;
  localparam logic [8:0] OCR_RST = 9'h100;
  localparam logic [8:0] GCR_RST = 9'h000;

  // frame length arithmetic
  localparam logic [7:0] LEN_MASK = 8'h0f;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [4:0] POS_ONE = 5'h01;
  localparam logic [4:0] POS_FULL = 5'h10;

  typedef struct packed {
    logic olon;
    logic oloff;
    logic os;
    logic ot;
    logic sc;
    logic oc;
  } srm_fault_t;

  typedef struct packed {
    logic clock_fail;
    logic cal_fail;
    logic overtemp_prewarning;
    logic wd_active;
    logic failsafe;
    logic [NUM_OUT-1:0] failsafe_out;
  } srm_diag_t;

  typedef struct packed {
    logic [NUM_OUT-1:0][DATA_W-1:0] pwm;
    logic [NUM_OUT-1:0][DATA_W-1:0] conf0;
    logic [NUM_OUT-1:0][DATA_W-1:0] conf1;
    logic [NUM_OUT-1:0][DATA_W-1:0] overcurrent_profile_register;
    logic [DATA_W-1:0] global_config_register;
  } srm_cfg_t;

  typedef struct packed {
    logic [WORD_W-1:0] shift;
    logic [CNT_W-1:0] cnt;
  } srm_rx_t;

  typedef struct packed {
    logic [POS_W-1:0] pos;
    logic so;
  } srm_tx_t;

endpackage

/* srm_sync.sv */
// Purpose: two-stage synchroniser for levels entering the clk domain
// Assumes: inputs are levels, not pulses shorter than two clk periods
// Notes: stage zero is read only by stage one
`timescale 1ns/1ps
module srm_sync #(
  parameter int W = 1
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic [W-1:0] d, // asynchronous level
  input wire logic [W-1:0] rst_val, // xor mask, sets the level read in reset
  output logic [W-1:0] q // synchronised level
);

  logic [1:0][W-1:0] stage_q;
  logic [1:0][W-1:0] stage_d;

  // shift the level through both stages
  always_comb
  begin
    stage_d = {stage_q[0], d};
  end

  // reset to zero; callers pick polarity so idle reads as expected
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage_q <= '0;
    end
    else
    begin
      stage_q <= stage_d;
    end
  end

  assign q = stage_q[1] ^ rst_val;

endmodule

/* srm_link.sv */
// Purpose: serial shifter on the link clock, framed by the chip select pin
// Assumes: mode 0 framing, master samples on rising, device drives on falling
// Notes: link clock is idle outside frames; chip select clears the output side
`timescale 1ns/1ps
module srm_link
  import srm_pkg::*;
(
  input wire logic sclk, // link clock from the master
  input wire logic rst, // async reset, active high
  input wire logic cs_n, // chip select pin, active low
  input wire logic si, // serial data in
  input wire logic [WORD_W-1:0] tx_word, // word to return, quasi-static
  output logic [WORD_W-1:0] rx_word, // last sixteen bits received
  output logic [CNT_W-1:0] rx_count, // free running received bit count
  output logic so_out, // serial data out
  output logic so_oe // serial out enable, high while driven
);

  srm_rx_t rx_q;
  srm_rx_t rx_d;
  srm_tx_t tx_q;
  srm_tx_t tx_d;
  logic [POS_W-1:0] pos_nx;

  // capture side: the count is never cleared by the select pin, so the
  // clk domain can measure a frame from two idle snapshots
  always_comb
  begin
    rx_d = rx_q;
    rx_d.shift = {rx_q.shift[WORD_W-2:0], si};
    rx_d.cnt = rx_q.cnt + CNT_ONE;
  end

  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
    begin
      rx_q <= '0;
    end
    else
    begin
      rx_q <= rx_d;
    end
  end

  // drive side: first sixteen bits from the returned word, later bits echo
  // what came in sixteen edges earlier so devices can be chained
  always_comb
  begin
    tx_d = tx_q;
    pos_nx = tx_q.pos + POS_ONE;
    if (tx_q.pos != POS_FULL)
    begin
      tx_d.pos = pos_nx;
    end
    if (pos_nx < POS_FULL)
    begin
      tx_d.so = tx_word[WORD_W-1-int'(pos_nx)];
    end
    else
    begin
      tx_d.so = rx_q.shift[WORD_W-1];
    end
  end

  // the select pin clears position with no clock edge, since the link clock
  // has stopped by the time the frame ends
  always_ff @(negedge sclk or posedge rst or posedge cs_n)
  begin
    if (rst || cs_n)
    begin
      tx_q <= '0;
    end
    else
    begin
      tx_q <= tx_d;
    end
  end

  // bit zero must show before any edge, so it bypasses the drive flop
  assign so_out = (tx_q.pos == '0) ? tx_word[WORD_W-1] : tx_q.so;
  assign so_oe = ~cs_n;
  assign rx_word = rx_q.shift;
  assign rx_count = rx_q.cnt;

endmodule

/* srm_readback.sv */
// Purpose: readback select mux and configuration store behind the serial port
// Assumes: fault and diagnostic inputs are on clk; pins and link are not
// Notes: the returned word is frozen while chip select is low
`timescale 1ns/1ps
module srm_readback
  import srm_pkg::*;
#(
  parameter logic [2:0] PRODUCT_ID = 3'h5 // arbitrary neutral value
) (
  input wire logic clk, // system clock, 20 MHz
  input wire logic rst, // async power-on reset, active high
  input wire logic sclk, // serial link clock
  input wire logic cs_n, // chip select pin, active low
  input wire logic si, // serial data in
  input wire logic [NUM_OUT-1:0] in_pins, // direct input pins
  input wire srm_fault_t [NUM_OUT-1:0] fault_in, // live fault flags per output
  input wire logic ov_in, // overvoltage flag
  input wire logic uv_in, // undervoltage flag
  input wire logic [NUM_OUT-1:0] fault_latch_evt, // latched fault event pulses
  input wire srm_diag_t diag_in, // diagnostic and watchdog state
  input wire logic normal_mode, // normal mode indicator
  output logic so_out, // serial data out
  output logic so_oe, // serial out enable
  output logic fault_status_pin_n, // fault status pin, active low
  output srm_cfg_t cfg_out // programmed configuration
);

  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic wd_prev;
    logic por;
    logic cs_prev;
    logic [CNT_W-1:0] end_cnt;
    logic [WORD_W-1:0] tx_word;
    logic [NUM_OUT-1:0] latch;
    logic fs_n;
    srm_cfg_t cfg;
  } srm_state_t;

  srm_state_t st_q;
  srm_state_t st_d;
  logic cs_s;
  logic [NUM_OUT-1:0] in_s;
  logic [WORD_W-1:0] link_rx;
  logic [CNT_W-1:0] link_cnt;
  logic [CNT_W-1:0] len;
  logic frame_done;
  logic len_ok;
  logic [1:0] rd_out;
  logic [2:0] rd_func;
  logic [1:0] wr_out;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] cfg_sel;
  logic [NUM_OUT-1:0] clr_v;
  srm_fault_t f_sel;

  // chip select idles high, so it syncs through the xor to read high in reset
  srm_sync #(
    .W(1)
  ) u_cs_sync (
    .clk(clk),
    .rst(rst),
    .d(~cs_n),
    .rst_val(1'b1),
    .q(cs_s)
  );

  // direct input pins are sampled live for the inputs readback
  srm_sync #(
    .W(NUM_OUT)
  ) u_in_sync (
    .clk(clk),
    .rst(rst),
    .d(in_pins),
    .rst_val('0),
    .q(in_s)
  );

  srm_link u_link (
    .sclk(sclk),
    .rst(rst),
    .cs_n(cs_n),
    .si(si),
    .tx_word(st_q.tx_word),
    .rx_word(link_rx),
    .rx_count(link_cnt),
    .so_out(so_out),
    .so_oe(so_oe)
  );

  // frame end is seen two clocks after chip select rises; the link is idle
  // then, so its word and count are stable to sample
  assign frame_done = cs_s & ~st_q.cs_prev;
  assign len = link_cnt - st_q.end_cnt;
  assign len_ok = (len != '0) && ((len & LEN_MASK) == '0);
  assign rd_out = st_q.sel[SEL_W-1:SEL_W-2];
  assign rd_func = st_q.sel[FUNC_HI:0];
  assign wr_out = link_rx[CMD_OUT_HI:CMD_OUT_LO];
  assign wr_data = link_rx[DATA_W-1:0];
  assign f_sel = fault_in[rd_out];

  // per-output configuration chosen by the low select bits
  always_comb
  begin
    if (rd_func == FUNC_PWM)
    begin
      cfg_sel = st_q.cfg.pwm[rd_out];
    end
    else if (rd_func == FUNC_CONF0)
    begin
      cfg_sel = st_q.cfg.conf0[rd_out];
    end
    else if (rd_func == FUNC_CONF1)
    begin
      cfg_sel = st_q.cfg.conf1[rd_out];
    end
    else
    begin
      cfg_sel = st_q.cfg.overcurrent_profile_register[rd_out];
    end
  end

  // readback payload decode; unlisted addresses return zero
  always_comb
  begin
    if (st_q.sel == SEL_GCR)
    begin
      rd_data = st_q.cfg.global_config_register;
    end
    else if (st_q.sel == SEL_DIAG0)
    begin
      rd_data = DATA_W'({diag_in.clock_fail, diag_in.cal_fail, diag_in.overtemp_prewarning});
    end
    else if (st_q.sel == SEL_DIAG1)
    begin
      rd_data = DATA_W'({(diag_in.failsafe ? diag_in.failsafe_out : in_s), diag_in.wd_active});
    end
    else if (st_q.sel == SEL_ID)
    begin
      rd_data = DATA_W'(PRODUCT_ID);
    end
    else if (rd_func == FUNC_STAT)
    begin
      rd_data = {st_q.por, uv_in, ov_in, f_sel.olon, f_sel.oloff, f_sel.os,
                 f_sel.ot, f_sel.sc, f_sel.oc};
    end
    else if (rd_func <= FUNC_OCR)
    begin
      rd_data = cfg_sel;
    end
    else
    begin
      rd_data = '0;
    end
  end

  // next state
  always_comb
  begin
    st_d = st_q;
    clr_v = '0;
    st_d.cs_prev = cs_s;
    // header built from last command; frozen during a frame
    if (cs_s)
    begin
      st_d.tx_word = {st_q.wd_prev, st_q.sel, normal_mode, rd_data};
    end
    if (frame_done)
    begin
      // invalid frames still move the snapshot so later lengths stay right
      st_d.end_cnt = link_cnt;
      if (len_ok)
      begin
        // cleared only by a valid status readout
        if (st_q.tx_word[SEL_LO+FUNC_HI:SEL_LO] == FUNC_STAT)
        begin
          st_d.por = 1'b0;
        end
        st_d.wd_prev = link_rx[WD_BIT];
        // select changes only on a select command
        if (link_rx[CMD_ADDR_HI:CMD_ADDR_LO] == CMD_SEL)
        begin
          st_d.sel = wr_data[SEL_W-1:0];
        end
        else if (link_rx[CMD_ADDR_HI:CMD_ADDR_LO] == CMD_PWM)
        begin
          // switch-off command: on bit falling
          clr_v[wr_out] = st_q.cfg.pwm[wr_out][PWM_ON_BIT] & ~wr_data[PWM_ON_BIT];
          st_d.cfg.pwm[wr_out] = wr_data;
        end
        else if (link_rx[CMD_ADDR_HI:CMD_ADDR_LO] == CMD_CONF0)
        begin
          st_d.cfg.conf0[wr_out] = wr_data;
        end
        else if (link_rx[CMD_ADDR_HI:CMD_ADDR_LO] == CMD_CONF1)
        begin
          st_d.cfg.conf1[wr_out] = wr_data;
        end
        else if (link_rx[CMD_ADDR_HI:CMD_ADDR_LO] == CMD_OCR)
        begin
          st_d.cfg.overcurrent_profile_register[wr_out] = wr_data;
        end
        else if (link_rx[CMD_ADDR_HI:CMD_ADDR_LO] == CMD_GCR)
        begin
          st_d.cfg.global_config_register = wr_data;
        end
      end
    end
    // a new event beats a same-cycle switch-off
    st_d.latch = (st_q.latch & ~clr_v) | fault_latch_evt;
    st_d.fs_n = ~((|fault_in) | ov_in | uv_in | (|st_q.latch));
  end

  // power-up values; the flag starts set because reset is the power-on event
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q.sel <= SEL_RST;
      st_q.wd_prev <= 1'b0;
      st_q.por <= 1'b1;
      st_q.cs_prev <= 1'b1;
      st_q.end_cnt <= '0;
      st_q.tx_word <= '0;
      st_q.latch <= '0;
      st_q.fs_n <= 1'b1;
      st_q.cfg.pwm <= {NUM_OUT{PWM_RST}};
      st_q.cfg.conf0 <= {NUM_OUT{CONF0_RST}};
      st_q.cfg.conf1 <= {NUM_OUT{CONF1_RST}};
      st_q.cfg.overcurrent_profile_register <= {NUM_OUT{OCR_RST}};
      st_q.cfg.global_config_register <= GCR_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign fault_status_pin_n = st_q.fs_n;
  assign cfg_out = st_q.cfg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_frame_ok;
    frame_done && len_ok;
  endsequence

  sequence s_status_shown;
    st_q.tx_word[SEL_LO+FUNC_HI:SEL_LO] == FUNC_STAT;
  endsequence

  a_por_keep: assert property (st_q.por && !(frame_done && len_ok) |=> st_q.por)
    else $error("power-on flag dropped without a valid readout");

  a_por_clear: assert property (s_frame_ok ##0 s_status_shown |=> !st_q.por)
    else $error("power-on flag not cleared after status readout");

  a_status_bits: assert property (cs_s && rd_func == FUNC_STAT && st_q.sel != SEL_GCR
      |=> st_q.tx_word[7:6] == {$past(uv_in), $past(ov_in)}
          && st_q.tx_word[0] == $past(f_sel.oc) && st_q.tx_word[8] == $past(st_q.por))
    else $error("status readback bits wrong");

  a_cfg_read: assert property (cs_s && rd_func >= FUNC_PWM && rd_func <= FUNC_OCR
      |=> st_q.tx_word[DATA_W-1:0] == $past(cfg_sel))
    else $error("output register readback wrong");

  a_gcr_read: assert property (cs_s && st_q.sel == SEL_GCR
      |=> st_q.tx_word[DATA_W-1:0] == $past(st_q.cfg.global_config_register))
    else $error("global config readback wrong");

  a_diag_first: assert property (cs_s && st_q.sel == SEL_DIAG0
      |=> st_q.tx_word[2:0] == $past({diag_in.clock_fail, diag_in.cal_fail, diag_in.overtemp_prewarning}))
    else $error("first diagnostic readback wrong");

  a_diag_inputs: assert property (cs_s && st_q.sel == SEL_DIAG1 && !diag_in.failsafe
      |=> st_q.tx_word[4:0] == {$past(in_s), $past(diag_in.wd_active)})
    else $error("input level readback wrong");

  a_diag_failsafe: assert property (cs_s && st_q.sel == SEL_DIAG1 && diag_in.failsafe
      |=> st_q.tx_word[4:1] == $past(diag_in.failsafe_out))
    else $error("fail-safe output report wrong");

  a_prod_id: assert property (cs_s && st_q.sel == SEL_ID
      |=> st_q.tx_word[DATA_W-1:0] == DATA_W'(PRODUCT_ID))
    else $error("product identification wrong");

  a_word_header: assert property (cs_s |=> st_q.tx_word[WD_BIT:NM_BIT]
      == {$past(st_q.wd_prev), $past(st_q.sel), $past(normal_mode)})
    else $error("returned word header wrong");

  a_sel_hold: assert property (!(frame_done && len_ok) |=> $stable(st_q.sel))
    else $error("readback select changed without command");

  a_fs_latch: assert property (fault_latch_evt != '0 |=> ##1 !fault_status_pin_n)
    else $error("fault pin not asserted for latched fault");

endmodule

/* srm_master.sv */
// Purpose: spi master model that frames commands and gathers the returned word
// Assumes: mode 0 link, link clock idle low and still between frames
// Notes: link clock runs at 12 ns only inside a frame, unrelated to clk
`timescale 1ns/1ps
module srm_master (
  output logic sclk, // link clock
  output logic cs_n, // chip select, active low
  output logic si, // serial data to the device
  input wire logic so_out, // serial data from the device
  input wire logic so_oe // device output enable
);
  // idle levels at time zero
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // one frame, msb first; the trailing gap keeps cs_n high for 12 clk
  task automatic xfer(input logic [31:0] data, input int nbits, output logic [31:0] rx);
    rx = 32'h0;
    cs_n = 1'b0;
    #200;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      si = data[i];
      #6;
      sclk = 1'b1;
      rx = {rx[30:0], so_out & so_oe}; // undriven output reads as zero
      #6;
      sclk = 1'b0;
    end
    #6;
    cs_n = 1'b1;
    si = ~si; // idle line shows the inverse so no stale bit looks valid
    #600;
  endtask
endmodule

/* spi_readback_status_mux_tb.sv */
// Purpose: self-checking bench for the readback select mux
// Assumes: master model frames every command; inputs change on clk rising
// Notes: every frame of sixteen bits or more compares the returned word with a model of the device
`timescale 1ns/1ps
module spi_readback_status_mux_tb;
  import srm_pkg::*;
  localparam logic [2:0] ID_VAL = 3'h2; // arbitrary product code
  logic clk, rst, sclk, cs_n, si, ov_in, uv_in, normal_mode, so_out, so_oe, pin_n;
  logic [NUM_OUT-1:0] in_pins, fault_latch_evt;
  srm_fault_t [NUM_OUT-1:0] fault_in;
  srm_diag_t diag_in;
  srm_cfg_t cfg_out;
  logic [8:0] m_pwm [NUM_OUT], m_conf0 [NUM_OUT], m_conf1 [NUM_OUT], m_ocr [NUM_OUT];
  logic [8:0] m_gcr;
  logic [4:0] m_sel;
  logic [4:0] sels [8];
  logic m_wd, m_por;
  logic [31:0] rnd;
  int err_count, samples_checked, seed;

  srm_readback #(.PRODUCT_ID(ID_VAL)) i_srm_readback (
    .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si), .in_pins(in_pins),
    .fault_in(fault_in), .ov_in(ov_in), .uv_in(uv_in), .fault_latch_evt(fault_latch_evt),
    .diag_in(diag_in), .normal_mode(normal_mode), .so_out(so_out), .so_oe(so_oe),
    .fault_status_pin_n(pin_n), .cfg_out(cfg_out)
  );

  srm_master i_srm_master (
    .sclk(sclk), .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe(so_oe)
  );

  // 20 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // returned word predicted from the model and the live inputs
  function automatic logic [15:0] exp_word();
    logic [8:0] p;
    logic [1:0] o;
    o = m_sel[4:3];
    case (m_sel[2:0])
      FUNC_STAT: p = {m_por, uv_in, ov_in, fault_in[o]};
      FUNC_PWM: p = m_pwm[o];
      FUNC_CONF0: p = m_conf0[o];
      FUNC_CONF1: p = m_conf1[o];
      FUNC_OCR: p = m_ocr[o];
      default: p = 9'h0;
    endcase
    if (m_sel == SEL_GCR)
      p = m_gcr;
    if (m_sel == SEL_DIAG0)
      p = {6'h0, diag_in.clock_fail, diag_in.cal_fail, diag_in.overtemp_prewarning};
    if (m_sel == SEL_DIAG1)
      p = {4'h0, diag_in.failsafe ? diag_in.failsafe_out : in_pins, diag_in.wd_active};
    if (m_sel == SEL_ID)
      p = {6'h0, ID_VAL};
    return {m_wd, m_sel, normal_mode, p};
  endfunction

  // command word with a random watchdog toggle bit
  function automatic logic [15:0] mk(input logic [3:0] a, input logic [1:0] o,
                                     input logic [8:0] d);
    logic [31:0] r;
    r = $random(seed);
    return {r[0], o, a, d};
  endfunction

  // one frame; refused lengths leave the model untouched
  task automatic run(input logic [15:0] cmd, input int nbits);
    logic [31:0] rx;
    logic [15:0] e;
    logic [1:0] o;
    e = exp_word();
    o = cmd[14:13];
    i_srm_master.xfer({16'h5a3c, cmd}, nbits, rx);
    if (nbits >= 16)
      chk("word", e, rx[nbits-1 -: 16]);
    if (nbits == 32)
      chk("echo", 16'h5a3c, rx[15:0]);
    if (nbits % 16 == 0)
    begin
      if (m_sel[2:0] == FUNC_STAT)
        m_por = 1'b0;
      m_wd = cmd[15];
      case (cmd[12:9])
        CMD_SEL: m_sel = cmd[4:0];
        CMD_PWM: m_pwm[o] = cmd[8:0];
        CMD_CONF0: m_conf0[o] = cmd[8:0];
        CMD_CONF1: m_conf1[o] = cmd[8:0];
        CMD_OCR: m_ocr[o] = cmd[8:0];
        CMD_GCR: m_gcr = cmd[8:0];
        default: ;
      endcase
    end
  endtask

  task automatic check_cfg();
    for (int o = 0; o < NUM_OUT; o++)
    begin
      chk("cfg_pwm", m_pwm[o], cfg_out.pwm[o]);
      chk("cfg_conf0", m_conf0[o], cfg_out.conf0[o]);
      chk("cfg_conf1", m_conf1[o], cfg_out.conf1[o]);
      chk("cfg_ocr", m_ocr[o], cfg_out.overcurrent_profile_register[o]);
    end
    chk("cfg_gcr", m_gcr, cfg_out.global_config_register);
  endtask

  // sparse faults so the fault pin is seen both ways
  task automatic rand_inputs();
    @(posedge clk);
    rnd = $random(seed);
    fault_in <= rnd[31] ? rnd[23:0] : 24'h0;
    ov_in <= rnd[24] & rnd[31];
    uv_in <= rnd[25] & rnd[31];
    normal_mode <= rnd[26];
    in_pins <= rnd[30:27];
    rnd = $random(seed);
    diag_in <= rnd[8:0];
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("fault_pin", {15'h0, !((|fault_in) || ov_in || uv_in)}, {15'h0, pin_n});
  endtask

  // hang guard, far beyond the expected run length
  initial
  begin
    #1000000;
    err_count++;
    final_report();
  end

  initial
  begin
    seed = 32'h806e;
    err_count = 0;
    samples_checked = 0;
    rst = 1'b1;
    fault_in = 24'h0;
    ov_in = 1'b0;
    uv_in = 1'b0;
    in_pins = 4'h0;
    fault_latch_evt = 4'h0;
    diag_in = 9'h0;
    normal_mode = 1'b1;
    for (int o = 0; o < NUM_OUT; o++)
    begin
      m_pwm[o] = PWM_RST;
      m_conf0[o] = CONF0_RST;
      m_conf1[o] = CONF1_RST;
      m_ocr[o] = OCR_RST;
    end
    m_gcr = GCR_RST;
    m_sel = SEL_RST;
    m_wd = 1'b0;
    m_por = 1'b1;
    sels = '{SEL_DIAG0, SEL_DIAG1, SEL_ID, 5'h00, 5'h08, 5'h10, 5'h18, 5'h1f};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    check_cfg();
    chk("so_oe_idle", 16'h0, {15'h0, so_oe});
    run(mk(CMD_SEL, 2'h0, {4'h0, SEL_ID}), 15);
    run(mk(CMD_SEL, 2'h0, {4'h0, SEL_ID}), 17);
    run(mk(4'h6, 2'h0, 9'h0), 16);
    run(mk(4'h6, 2'h0, 9'h0), 16);
    run(mk(CMD_SEL, 2'h0, {4'h0, SEL_GCR}), 32);
    run(mk(4'h6, 2'h0, 9'h0), 16);
    for (int o = 0; o < NUM_OUT; o++)
      for (int f = 1; f <= 4; f++)
      begin
        rand_inputs();
        run(mk(f[3:0], o[1:0], rnd[8:0]), 16);
        run(mk(CMD_SEL, 2'h0, {4'h0, o[1:0], f[2:0]}), 16);
        run(mk(4'h6, 2'h0, 9'h0), 16);
      end
    run(mk(CMD_GCR, 2'h0, rnd[17:9]), 16);
    run(mk(CMD_SEL, 2'h0, {4'h0, SEL_GCR}), 16);
    run(mk(4'h6, 2'h0, 9'h0), 16);
    foreach (sels[i])
    begin
      run(mk(CMD_SEL, 2'h0, {4'h0, sels[i]}), 16);
      repeat (3)
      begin
        rand_inputs();
        run(mk(4'h6, 2'h0, 9'h0), 16);
      end
    end
    // latched fault holds the pin until its own switch-off command
    @(posedge clk);
    fault_in <= 24'h0;
    ov_in <= 1'b0;
    uv_in <= 1'b0;
    run(mk(CMD_PWM, 2'h2, 9'h080), 16);
    run(mk(CMD_PWM, 2'h1, 9'h080), 16);
    chk("pin_idle", 16'h1, {15'h0, pin_n});
    @(posedge clk);
    fault_latch_evt <= 4'h4;
    @(posedge clk);
    fault_latch_evt <= 4'h0;
    repeat (20) @(posedge clk);
    run(mk(CMD_PWM, 2'h1, 9'h000), 16);
    chk("pin_latched", 16'h0, {15'h0, pin_n});
    run(mk(CMD_PWM, 2'h2, 9'h000), 16);
    chk("pin_cleared", 16'h1, {15'h0, pin_n});
    check_cfg();
    final_report();
  end
endmodule
